// [serial_sync_regs.svh]
// Purpose: register offsets, status bit positions and field layouts
// Assumes: word-indexed plain register port, 32-bit data
// Notes:   shared by the package and the status/irq logic
`ifndef SERIAL_SYNC_REGS_SVH
`define SERIAL_SYNC_REGS_SVH
`define ADDR_TX_SYNC_WORD   4'h0
`define ADDR_SERIAL_STATUS  4'h1
`define ADDR_IRQ_SET        4'h2
`define ADDR_IRQ_CLEAR      4'h3
`define ADDR_IRQ_MASK_VIEW  4'h4
`define SYNC_WORD_MSB       15
`define BIT_TX_HOLDING_FREE 0
`define BIT_TX_ALL_SENT     1
`define BIT_TX_DMA_DONE     2
`define BIT_TX_DMA_ZERO     3
`define BIT_RX_WORD_AVAIL   4
`define BIT_RX_WORD_LOST    5
`define BIT_RX_DMA_DONE     6
`define BIT_RX_DMA_ZERO     7
`define BIT_TX_SYNC_SEEN    10
`define BIT_RX_SYNC_SEEN    11
`define BIT_TRANSMITTER_ON  16
`define BIT_RECEIVER_ON     17
`define IRQ_BITS_MASK       32'h0000_0cff
`define FS_EDGE_RISING      1'h0
`define FS_EDGE_FALLING     1'h1
`define FS_LEN_W            4
`endif

// [serial_sync_pkg.sv]
// Purpose: shared types of the serial status block
// Assumes: nothing beyond the register header
// Notes:   types only; numbers live in the header
`default_nettype none
`include "serial_sync_regs.svh"
package serial_sync_pkg;
  typedef logic [31:0] word_type;             // one register word
  typedef logic [3:0]  reg_addr_type;         // register index
  typedef logic [15:0] sync_word_type;        // sync word field
  typedef logic [`FS_LEN_W-1:0] fs_len_type;  // frame sync length field
  typedef enum logic [1:0] {                   // sync shifter states
    SHIFT_IDLE,
    SHIFT_WAIT_FS,
    SHIFT_RUN
  } shift_state_type;
endpackage : serial_sync_pkg
`default_nettype wire

// [sync_shift_if.sv]
// Purpose: link between status block and sync word shifter
// Assumes: single clock domain
// Notes:   owner drives word and length, shifter drives bit out
`timescale 1ns/1ns
`default_nettype none
interface sync_shift_if;
  logic [15:0] word;     // sync word to shift
  logic [3:0]  length;   // frame sync length minus one
  logic        enable;   // frame sync data on
  logic        fs_start; // start of transmit frame sync
  logic        bit_out;  // bit on the data line
  logic        active;   // shifting in progress
  modport owner   (output word, length, enable, fs_start, input bit_out, active);
  modport shifter (input word, length, enable, fs_start, output bit_out, active);
endinterface : sync_shift_if
`default_nettype wire

// [sync_word_shifter.sv]
// Purpose: shift sync word bits out during transmit frame sync
// Assumes: fs_start is a one-cycle pulse at frame sync start
// Notes:   lsb first, length field plus one bits
`timescale 1ns/1ns
`default_nettype none
`include "serial_sync_regs.svh"
module sync_word_shifter
  import serial_sync_pkg::*;
(
  input  wire logic sys_clk_i, // system clock
  input  wire logic rst_i,     // async reset, active high
  sync_shift_if.shifter link   // sync word link
);
  shift_state_type state_q;    // shifter state
  logic [15:0]     shreg_q;    // shifting copy of the word
  logic [3:0]      left_q;     // bits remaining minus one
  logic            out_q;      // registered line bit
  wire             go = link.fs_start && link.enable; // start condition

  assign link.bit_out = out_q;
  assign link.active  = (state_q != SHIFT_IDLE); // last bit still stands in wait state

  // load on frame sync start, then one bit per clock
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state_q <= SHIFT_IDLE;
      shreg_q <= 16'h0000;
      left_q  <= 4'h0;
      out_q   <= 1'b0;
    end
    else
    begin
      case (state_q)
        SHIFT_IDLE:
        begin
          if (go)
          begin
            out_q   <= link.word[0];
            shreg_q <= {1'b0, link.word[15:1]};
            left_q  <= link.length;
            state_q <= (link.length == 4'h0) ? SHIFT_WAIT_FS : SHIFT_RUN;
          end
        end
        SHIFT_RUN:
        begin
          out_q   <= shreg_q[0];
          shreg_q <= {1'b0, shreg_q[15:1]};
          left_q  <= left_q - 4'h1;
          if (left_q == 4'h1)
            state_q <= SHIFT_WAIT_FS;
        end
        SHIFT_WAIT_FS:
        begin
          out_q   <= 1'b0;
          state_q <= SHIFT_IDLE;
        end
        default: state_q <= SHIFT_IDLE;
      endcase
    end
  end
endmodule : sync_word_shifter
`default_nettype wire

// [serial_sync_status_irq.sv]
// Purpose: status word, sync word and interrupt mask of serial controller
// Assumes: datapath and dma inputs on sys_clk_i; frame sync pin asynchronous
// Notes:   read data valid the cycle after the read strobe only
`timescale 1ns/1ns
`default_nettype none
`include "serial_sync_regs.svh"
module serial_sync_status_irq
  import serial_sync_pkg::*;
#(
  parameter int CNT_W = 16                        // dma counter width
)(
  input  wire logic                       sys_clk_i,        // 50 MHz clock
  input  wire logic                       rst_i,            // async reset
  input  wire serial_sync_pkg::reg_addr_type reg_addr_i,    // register index
  input  wire serial_sync_pkg::word_type  reg_wdata_i,      // write data
  input  wire logic                       reg_wr_i,         // write strobe
  input  wire logic                       reg_rd_i,         // read strobe
  output var  serial_sync_pkg::word_type  reg_rdata_o,      // read data
  input  wire logic                       thr_write_i,      // tx holding written
  input  wire logic                       thr_load_i,       // holding to shifter
  input  wire logic                       tx_shift_busy_i,  // shifter busy
  input  wire logic                       rhr_load_i,       // rx word loaded
  input  wire logic                       rhr_read_i,       // rx holding read
  input  wire logic [CNT_W-1:0]           tx_cnt_i,         // tx dma counter
  input  wire logic [CNT_W-1:0]           tx_next_cnt_i,    // tx dma next counter
  input  wire logic                       tx_cnt_wr_i,      // tx counter written
  input  wire logic [CNT_W-1:0]           rx_cnt_i,         // rx dma counter
  input  wire logic [CNT_W-1:0]           rx_next_cnt_i,    // rx dma next counter
  input  wire logic                       rx_cnt_wr_i,      // rx counter written
  input  wire logic                       tx_fs_pin_i,      // tx frame sync pin
  input  wire logic                       rx_sync_evt_i,    // rx sync pulse
  input  wire logic                       transmitter_on_i, // transmitter enabled
  input  wire logic                       receiver_on_i,    // receiver enabled
  input  wire logic                       frame_sync_data_on_i,     // send sync word
  input  wire logic                       frame_sync_edge_select_i, // 0 rise 1 fall
  input  wire serial_sync_pkg::fs_len_type frame_sync_length_i,     // length field
  output logic                            sync_bit_o,       // sync word bit
  output logic                            sync_active_o,    // sync word shifting
  output logic                            irq_o             // peripheral interrupt
);
  import serial_sync_pkg::*;

  // register state
  sync_word_type tx_sync_word_q;   // sync word bits
  word_type      irq_mask_q;       // enabled interrupts
  word_type      rdata_q;          // read data register
  logic          irq_q;            // interrupt output register
  logic          sync_bit_q;       // registered sync bit
  logic          sync_act_q;       // registered shifting flag
  // status flags
  logic          holding_full_q;   // tx holding occupied
  logic          tx_all_sent_q;    // last word gone
  logic          tx_dma_done_q;    // tx counter hit zero
  logic          rx_avail_q;       // rx holding occupied
  logic          rx_lost_q;        // overrun
  logic          rx_dma_done_q;    // rx counter hit zero
  logic          tx_sync_q;        // tx sync seen
  logic          rx_sync_q;        // rx sync seen
  logic          tx_cnt_zero_q;    // last tx counter zero state
  logic          rx_cnt_zero_q;    // last rx counter zero state
  // frame sync pin synchroniser
  logic [2:0]    fs_sync_q;        // three stage chain
  logic          fs_level_q;       // accepted pin level

  // bus decode
  wire wr_sync  = reg_wr_i && (reg_addr_i == `ADDR_TX_SYNC_WORD);
  wire wr_set   = reg_wr_i && (reg_addr_i == `ADDR_IRQ_SET);
  wire wr_clr   = reg_wr_i && (reg_addr_i == `ADDR_IRQ_CLEAR);
  wire rd_stat  = reg_rd_i && (reg_addr_i == `ADDR_SERIAL_STATUS);

  // level flags and zero-reaching edges derived from counters
  wire tx_both_zero = (tx_cnt_i == '0) && (tx_next_cnt_i == '0);
  wire rx_both_zero = (rx_cnt_i == '0) && (rx_next_cnt_i == '0);
  wire tx_cnt_zero  = (tx_cnt_i == '0);
  wire rx_cnt_zero  = (rx_cnt_i == '0);
  wire tx_reach     = tx_cnt_zero && !tx_cnt_zero_q;
  wire rx_reach     = rx_cnt_zero && !rx_cnt_zero_q;

  // frame sync edge, pin change accepted when stages two and three agree
  wire fs_agree  = (fs_sync_q[1] == fs_sync_q[2]);
  wire fs_new    = fs_agree ? fs_sync_q[2] : fs_level_q;
  wire fs_rise   = fs_new && !fs_level_q;
  wire fs_fall   = !fs_new && fs_level_q;
  wire tx_fs_evt = (frame_sync_edge_select_i == `FS_EDGE_FALLING) ? fs_fall : fs_rise;

  wire rx_overrun = rhr_load_i && rx_avail_q && !rhr_read_i;

  // assembled status word
  word_type status_w;
  always_comb
  begin
    status_w = '0;
    status_w[`BIT_TX_HOLDING_FREE] = !holding_full_q;
    status_w[`BIT_TX_ALL_SENT]     = tx_all_sent_q;
    status_w[`BIT_TX_DMA_DONE]     = tx_dma_done_q;
    status_w[`BIT_TX_DMA_ZERO]     = tx_both_zero;
    status_w[`BIT_RX_WORD_AVAIL]   = rx_avail_q;
    status_w[`BIT_RX_WORD_LOST]    = rx_lost_q;
    status_w[`BIT_RX_DMA_DONE]     = rx_dma_done_q;
    status_w[`BIT_RX_DMA_ZERO]     = rx_both_zero;
    status_w[`BIT_TX_SYNC_SEEN]    = tx_sync_q;
    status_w[`BIT_RX_SYNC_SEEN]    = rx_sync_q;
    status_w[`BIT_TRANSMITTER_ON]  = transmitter_on_i;
    status_w[`BIT_RECEIVER_ON]     = receiver_on_i;
  end

  // read multiplexer; unmapped indices read zero
  word_type rd_mux;
  always_comb
  begin
    case (reg_addr_i)
      `ADDR_TX_SYNC_WORD:  rd_mux = {16'h0000, tx_sync_word_q};
      `ADDR_SERIAL_STATUS: rd_mux = status_w;
      `ADDR_IRQ_MASK_VIEW: rd_mux = irq_mask_q;
      default:             rd_mux = '0;
    endcase
  end

  // next mask and next interrupt
  wire word_type mask_d = (irq_mask_q | (wr_set ? reg_wdata_i : '0))
                          & ~(wr_clr ? reg_wdata_i : '0)
                          & `IRQ_BITS_MASK;
  wire irq_d = |(status_w & irq_mask_q);

  // sync word shifter link
  sync_shift_if shift_link();
  assign shift_link.word     = tx_sync_word_q;
  assign shift_link.length   = frame_sync_length_i;
  assign shift_link.enable   = frame_sync_data_on_i;
  assign shift_link.fs_start = tx_fs_evt;

  sync_word_shifter u_shifter (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .link      (shift_link)
  );

  // register writes, read data, outputs
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      tx_sync_word_q <= 16'h0000;
      irq_mask_q     <= 32'h0000_0000;
      rdata_q        <= 32'h0000_0000;
      irq_q          <= 1'b0;
      sync_bit_q     <= 1'b0;
      sync_act_q     <= 1'b0;
    end
    else
    begin
      if (wr_sync)
        tx_sync_word_q <= reg_wdata_i[`SYNC_WORD_MSB:0];
      irq_mask_q <= mask_d;
      rdata_q    <= reg_rd_i ? rd_mux : 32'h0000_0000;
      irq_q      <= irq_d;
      sync_bit_q <= shift_link.bit_out;
      sync_act_q <= shift_link.active;
    end
  end

  // transmit side flags
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      holding_full_q <= 1'b0;
      tx_all_sent_q  <= 1'b1;
      tx_dma_done_q  <= 1'b0;
      tx_cnt_zero_q  <= 1'b1;
    end
    else
    begin
      tx_cnt_zero_q <= tx_cnt_zero;
      if (thr_write_i)
        holding_full_q <= 1'b1;
      else if (thr_load_i)
        holding_full_q <= 1'b0;
      tx_all_sent_q <= !thr_write_i && !holding_full_q && !tx_shift_busy_i
                       && !thr_load_i;
      if (tx_reach)
        tx_dma_done_q <= 1'b1;
      else if (tx_cnt_wr_i)
        tx_dma_done_q <= 1'b0;
    end
  end

  // receive side and sticky sync flags
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      rx_avail_q    <= 1'b0;
      rx_lost_q     <= 1'b0;
      rx_dma_done_q <= 1'b0;
      rx_cnt_zero_q <= 1'b1;
      tx_sync_q     <= 1'b0;
      rx_sync_q     <= 1'b0;
    end
    else
    begin
      rx_cnt_zero_q <= rx_cnt_zero;
      if (rhr_load_i)
        rx_avail_q <= 1'b1;
      else if (rhr_read_i)
        rx_avail_q <= 1'b0;
      if (rx_overrun)
        rx_lost_q <= 1'b1;
      else if (rd_stat)
        rx_lost_q <= 1'b0;
      if (rx_reach)
        rx_dma_done_q <= 1'b1;
      else if (rx_cnt_wr_i)
        rx_dma_done_q <= 1'b0;
      if (tx_fs_evt)
        tx_sync_q <= 1'b1;
      else if (rd_stat)
        tx_sync_q <= 1'b0;
      if (rx_sync_evt_i)
        rx_sync_q <= 1'b1;
      else if (rd_stat)
        rx_sync_q <= 1'b0;
    end
  end

  // frame sync pin synchroniser
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      fs_sync_q  <= 3'h0;
      fs_level_q <= 1'b0;
    end
    else
    begin
      fs_sync_q  <= {fs_sync_q[1:0], tx_fs_pin_i};
      fs_level_q <= fs_new;
    end
  end

  assign reg_rdata_o   = rdata_q;
  assign irq_o         = irq_q;
  assign sync_bit_o    = sync_bit_q;
  assign sync_active_o = sync_act_q;

  // checks: every flag but tx_all_sent_q against its setting and clearing events
  // registered flags are looked at one cycle after their cause
  chk_set_enables: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    wr_set && reg_wdata_i[`BIT_RX_WORD_AVAIL] |=> irq_mask_q[`BIT_RX_WORD_AVAIL])
    else $error("set write did not enable mask bit");
  chk_clr_disables: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    wr_clr && !wr_set && reg_wdata_i[`BIT_TX_HOLDING_FREE]
      |=> !irq_mask_q[`BIT_TX_HOLDING_FREE])
    else $error("clear write did not disable mask bit");
  chk_mask_readback: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    reg_rd_i && reg_addr_i == `ADDR_IRQ_MASK_VIEW |=> reg_rdata_o == $past(irq_mask_q))
    else $error("mask view read mismatch");

  // interrupt output against flags and mask, sync and overrun flags, tx done clear, status read
  chk_irq_raise: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    rx_sync_q && irq_mask_q[`BIT_RX_SYNC_SEEN] |=> irq_o)
    else $error("interrupt missing for enabled flag");
  chk_irq_quiet: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    irq_mask_q == '0 |=> !irq_o)
    else $error("interrupt raised with all masked");
  chk_sync_read_clear: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    rd_stat && !tx_fs_evt |=> !tx_sync_q)
    else $error("tx sync flag survived status read");
  chk_event_wins: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    rx_sync_evt_i |=> rx_sync_q[*2] or (rx_sync_q ##1 $past(rd_stat)))
    else $error("rx sync flag lost");
  chk_overrun_set: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    rx_overrun |=> rx_lost_q)
    else $error("overrun not flagged");
  chk_tx_done_clr: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    tx_cnt_wr_i && !tx_reach |=> !tx_dma_done_q)
    else $error("tx done not cleared by counter write");
  chk_status_rdata: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    rd_stat ##1 transmitter_on_i && $past(transmitter_on_i)
      |-> reg_rdata_o[`BIT_TRANSMITTER_ON])
    else $error("transmitter on not reported");

  // transmit holding, shifter and counter flags
  chk_holding_taken: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    thr_write_i |=> !status_w[`BIT_TX_HOLDING_FREE])
    else $error("holding free after write");
  chk_holding_freed: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    thr_load_i && !thr_write_i |=> status_w[`BIT_TX_HOLDING_FREE])
    else $error("holding not free after load");
  chk_busy_not_sent: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    tx_shift_busy_i |=> !tx_all_sent_q)
    else $error("all sent while shifter busy");
  chk_tx_done_set: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    $rose(tx_cnt_i == '0) |=> tx_dma_done_q)
    else $error("tx done not set at zero");
  chk_tx_zero_rd: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    rd_stat && (tx_cnt_i != '0 || tx_next_cnt_i != '0) |=> !reg_rdata_o[`BIT_TX_DMA_ZERO])
    else $error("tx both zero with count left");

  // receive holding and counter flags
  chk_rx_avail_set: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    rhr_load_i |=> rx_avail_q)
    else $error("rx word not flagged");
  chk_rx_avail_clr: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    rhr_read_i && !rhr_load_i |=> !rx_avail_q)
    else $error("rx word flag kept after read");
  chk_lost_needs_word: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    rhr_load_i && !rx_avail_q && !rx_lost_q |=> !rx_lost_q)
    else $error("overrun without unread word");
  chk_rx_done_set: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    $rose(rx_cnt_i == '0) |=> rx_dma_done_q)
    else $error("rx done not set at zero");
  chk_rx_done_clr: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    rx_cnt_wr_i && !$rose(rx_cnt_i == '0) |=> !rx_dma_done_q)
    else $error("rx done not cleared by write");
  chk_rx_zero_rd: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    rd_stat && (rx_cnt_i != '0 || rx_next_cnt_i != '0) |=> !reg_rdata_o[`BIT_RX_DMA_ZERO])
    else $error("rx both zero with count left");

  // sticky flags and frame sync edge
  chk_tx_sync_set: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    tx_fs_evt |=> tx_sync_q)
    else $error("tx sync not flagged");
  chk_rx_sync_set: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    rx_sync_evt_i |=> rx_sync_q)
    else $error("rx sync not flagged");
  chk_rx_sync_clr: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    rd_stat && !rx_sync_evt_i |=> !rx_sync_q)
    else $error("rx sync survived status read");
  chk_overrun_clr: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    rd_stat && !rx_overrun |=> !rx_lost_q)
    else $error("overrun survived status read");
  chk_edge_ignored: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    frame_sync_edge_select_i == `FS_EDGE_RISING && fs_fall && !rd_stat && !tx_sync_q
      |=> !tx_sync_q)
    else $error("tx sync set on unselected edge");

  // read data and sync word shifting
  chk_receiver_rdata: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    rd_stat ##1 receiver_on_i && $past(receiver_on_i) |-> reg_rdata_o[`BIT_RECEIVER_ON])
    else $error("receiver on not reported");
  chk_sync_word_high: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    reg_rd_i && reg_addr_i == `ADDR_TX_SYNC_WORD |=> reg_rdata_o[31:16] == 16'h0000)
    else $error("sync word upper half not zero");
  chk_shift_off: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    tx_fs_evt && !frame_sync_data_on_i && !shift_link.active |=> !shift_link.active)
    else $error("sync word shifted while disabled");
  chk_sync_bits_len: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    tx_fs_evt && frame_sync_data_on_i && frame_sync_length_i == 4'h3 && !shift_link.active
      |=> ##1 sync_act_q[*4] ##1 !sync_act_q)
    else $error("sync word bit count wrong");
endmodule : serial_sync_status_irq
`default_nettype wire

// [dma_count_model.sv]
// Purpose: far-side dma counter pair that feeds the status block
// Assumes: bench pulses load and step for one cycle each
// Notes:   a step on a zero current count pulls the next count in
`timescale 1ns/1ns
`default_nettype none
module dma_count_model #(
  parameter int W = 16                  // counter width
)(
  input  wire logic         sys_clk_i,  // system clock
  input  wire logic         rst_i,      // async reset, active high
  input  wire logic         ld_i,       // software writes both counters
  input  wire logic [W-1:0] cur_i,      // new current count
  input  wire logic [W-1:0] nxt_i,      // new next count
  input  wire logic         step_i,     // one transfer finished
  output logic [W-1:0]      cnt_o,      // current count
  output logic [W-1:0]      next_o,     // next count
  output logic              wr_o        // counter write pulse
);
  // counters move only by a write or a finished transfer
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      cnt_o  <= '0;
      next_o <= '0;
      wr_o   <= 1'b0;
    end
    else
    begin
      wr_o <= ld_i;
      // write pulse comes with the new values, as software sees it
      if (ld_i)
      begin
        cnt_o  <= cur_i;
        next_o <= nxt_i;
      end
      else if (step_i && cnt_o != '0)
        cnt_o <= cnt_o - 1'b1;
      // reload from next buffer once the current one ran dry
      else if (step_i && next_o != '0)
      begin
        cnt_o  <= next_o;
        next_o <= '0;
      end
    end
  end
endmodule : dma_count_model
`default_nettype wire

// [testbench.sv]
// Purpose: register-level test of the serial status and irq block
// Assumes: read data stand in the cycle after the read strobe
// Notes:   event inputs are one-cycle pulses from the ev vector
`timescale 1ns/1ns
`default_nettype none
`include "serial_sync_regs.svh"
module testbench;
  import serial_sync_pkg::*;
  logic         sys_clk_i, rst_i, wr, rd, busy, fs_pin, tx_on, rx_on, fsd_on, fs_edge;
  logic         sync_bit, sync_active, irq;
  logic [8:0]   ev;              // event pulses, see task pulse
  reg_addr_type addr;            // register index
  word_type     wdata, rdata, rd_val;
  fs_len_type   fs_len;          // frame sync length field
  logic [15:0]  tx_cur, tx_nxt, rx_cur, rx_nxt, tx_cnt, tx_next, rx_cnt, rx_next;
  logic [15:0]  got;             // collected sync bits
  logic         tx_wr, rx_wr;    // counter write pulses
  int           err_total, checks_done, n;

  serial_sync_status_irq #(.CNT_W(16)) u_serial_sync_status_irq (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .thr_write_i(ev[0]),
    .thr_load_i(ev[1]), .tx_shift_busy_i(busy), .rhr_load_i(ev[2]), .rhr_read_i(ev[3]),
    .tx_cnt_i(tx_cnt), .tx_next_cnt_i(tx_next), .tx_cnt_wr_i(tx_wr), .rx_cnt_i(rx_cnt),
    .rx_next_cnt_i(rx_next), .rx_cnt_wr_i(rx_wr), .tx_fs_pin_i(fs_pin),
    .rx_sync_evt_i(ev[8]), .transmitter_on_i(tx_on), .receiver_on_i(rx_on),
    .frame_sync_data_on_i(fsd_on), .frame_sync_edge_select_i(fs_edge),
    .frame_sync_length_i(fs_len), .sync_bit_o(sync_bit), .sync_active_o(sync_active),
    .irq_o(irq));
  // transmit and receive dma channels on the far side
  dma_count_model u_tx_dma (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .ld_i(ev[4]),
    .cur_i(tx_cur), .nxt_i(tx_nxt), .step_i(ev[5]), .cnt_o(tx_cnt), .next_o(tx_next),
    .wr_o(tx_wr));
  dma_count_model u_rx_dma (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .ld_i(ev[6]),
    .cur_i(rx_cur), .nxt_i(rx_nxt), .step_i(ev[7]), .cnt_o(rx_cnt), .next_o(rx_next),
    .wr_o(rx_wr));

  // 50 MHz clock
  initial
  begin
    sys_clk_i = 1'b0;
    forever #10 sys_clk_i = ~sys_clk_i;
  end

  // compare and count
  task automatic check(input word_type seen, input word_type exp);
    checks_done++;
    if (seen !== exp)
    begin
      err_total++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // one-cycle write on the register port
  task automatic reg_write(input reg_addr_type a, input word_type d);
    @(posedge sys_clk_i);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge sys_clk_i);
    wr    <= 1'b0;
  endtask : reg_write

  // one-cycle read, data taken in the following cycle only
  task automatic reg_read(input reg_addr_type a, output word_type d);
    @(posedge sys_clk_i);
    addr <= a;
    rd   <= 1'b1;
    @(posedge sys_clk_i);
    rd   <= 1'b0;
    @(negedge sys_clk_i);
    d = rdata;
  endtask : reg_read

  // read status and compare one bit
  task automatic status_bit(input int b, input logic e);
    reg_read(`ADDR_SERIAL_STATUS, rd_val);
    check({31'h0, rd_val[b]}, {31'h0, e});
  endtask : status_bit

  // one-cycle pulse on an event line, then let two edges pass
  task automatic pulse(input int i);
    @(posedge sys_clk_i);
    ev[i] <= 1'b1;
    @(posedge sys_clk_i);
    ev[i] <= 1'b0;
    repeat (2) @(posedge sys_clk_i);
  endtask : pulse

  // verdict and end of run
  task automatic end_sim;
    $display("errors %0d checks %0d", err_total, checks_done);
    if (err_total == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : end_sim

  initial
  begin
    {rst_i, wr, rd, busy, fs_pin, tx_on, rx_on, fsd_on, fs_edge} = 9'h100;
    {ev, addr, wdata, fs_len, tx_nxt, rx_nxt} = '0;
    tx_cur = 16'h0002;
    rx_cur = 16'h0001;
    err_total = 0;
    checks_done = 0;
    repeat (10) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    // reset view, refused write to status, unmapped index
    reg_write(`ADDR_SERIAL_STATUS, 32'hffff_ffff);
    reg_read(`ADDR_SERIAL_STATUS, rd_val);
    check(rd_val, 32'h0000_008b);
    reg_read(`ADDR_IRQ_MASK_VIEW, rd_val);
    check(rd_val, 32'h0);
    reg_read(4'h5, rd_val);
    check(rd_val, 32'h0);
    // sync word keeps only its low half
    reg_write(`ADDR_TX_SYNC_WORD, 32'hdead_beef);
    reg_read(`ADDR_TX_SYNC_WORD, rd_val);
    check(rd_val, 32'h0000_beef);
    // mask set, clear, no-effect zeros, irq follows
    reg_write(`ADDR_IRQ_SET, 32'hffff_ffff);
    reg_read(`ADDR_IRQ_MASK_VIEW, rd_val);
    check(rd_val, `IRQ_BITS_MASK);
    check({31'h0, irq}, 32'h1);
    reg_write(`ADDR_IRQ_CLEAR, 32'h0000_0f8f);
    reg_write(`ADDR_IRQ_SET, 32'h0);
    reg_read(`ADDR_IRQ_MASK_VIEW, rd_val);
    check(rd_val, 32'h0000_0070);
    check({31'h0, irq}, 32'h0);
    reg_write(`ADDR_IRQ_CLEAR, 32'hffff_ffff);
    // transmit holding and shifter
    pulse(0);
    status_bit(0, 1'b0);
    status_bit(1, 1'b0);
    @(posedge sys_clk_i) busy <= 1'b1;
    pulse(1);
    status_bit(0, 1'b1);
    status_bit(1, 1'b0);
    @(posedge sys_clk_i) busy <= 1'b0;
    repeat (3) @(posedge sys_clk_i);
    status_bit(1, 1'b1);
    // receive holding and overrun
    pulse(2);
    status_bit(4, 1'b1);
    status_bit(5, 1'b0);
    pulse(2);
    status_bit(5, 1'b1);
    status_bit(5, 1'b0);
    pulse(3);
    status_bit(4, 1'b0);
    // transmit dma counters
    pulse(4);
    status_bit(3, 1'b0);
    pulse(5);
    pulse(5);
    status_bit(2, 1'b1);
    status_bit(3, 1'b1);
    @(posedge sys_clk_i) {tx_cur, tx_nxt} <= {16'h0, 16'h0001};
    pulse(4);
    status_bit(2, 1'b0);
    status_bit(3, 1'b0);
    // receive dma counters
    pulse(6);
    status_bit(7, 1'b0);
    pulse(7);
    status_bit(6, 1'b1);
    status_bit(7, 1'b1);
    pulse(6);
    status_bit(6, 1'b0);
    // receive sync with its interrupt
    reg_write(`ADDR_IRQ_SET, 32'h0000_0800);
    pulse(8);
    check({31'h0, irq}, 32'h1);
    status_bit(11, 1'b1);
    status_bit(11, 1'b0);
    check({31'h0, irq}, 32'h0);
    // transmit sync on the selected pin edge only
    for (int s = 0; s < 2; s++)
    begin
      @(posedge sys_clk_i) {fs_edge, fs_pin} <= {s[0], 1'b1};
      repeat (8) @(posedge sys_clk_i);
      status_bit(10, s == 0);
      status_bit(10, 1'b0);
      @(posedge sys_clk_i) fs_pin <= 1'b0;
      repeat (8) @(posedge sys_clk_i);
      status_bit(10, s == 1);
    end
    // enable levels
    @(posedge sys_clk_i) {tx_on, rx_on} <= 2'b11;
    reg_read(`ADDR_SERIAL_STATUS, rd_val);
    check(rd_val & 32'h0003_0000, 32'h0003_0000);
    // sync word shifted out during frame sync, lsb first
    reg_write(`ADDR_TX_SYNC_WORD, 32'h0000_000a);
    @(posedge sys_clk_i) {fs_edge, fsd_on, fs_len} <= {2'b01, 4'h3};
    @(posedge sys_clk_i) fs_pin <= 1'b1;
    got = '0;
    n = 0;
    repeat (40)
    begin
      @(negedge sys_clk_i);
      if (sync_active === 1'b1 && n < 16)
      begin
        got[n] = sync_bit;
        n++;
      end
    end
    check({16'h0, got}, 32'h0000_000a);
    check(32'(n), 32'h4);
    end_sim();
  end
endmodule : testbench
`default_nettype wire
